// [logic/reset_boot_pkg.sv]
// Constants and types for the reset and boot sequencer
package reset_boot_pkg;

    // ============================================================
    // Timing in state times (one state time is one sys_clk cycle)
    localparam int unsigned RESET_MIN_STATES = 16;
    localparam int unsigned BOOT_SEQ_STATES  = 10;
    localparam int unsigned LOW_CNT_W        = 5;
    localparam int unsigned SEQ_CNT_W        = 4;

    // ============================================================
    // Boot step schedule within the sequence
    localparam logic [3:0] STEP_CLEAR  = 4'h0;
    localparam logic [3:0] STEP_CAP0   = 4'h2;
    localparam logic [3:0] STEP_CAP1   = 4'h4;
    localparam logic [3:0] STEP_CAP2   = 4'h6;
    localparam logic [3:0] STEP_JUMP   = 4'h9;

    // ============================================================
    // Addresses
    localparam logic [23:0] CFG0_ADDR       = 24'h002018;
    localparam logic [23:0] CFG1_ADDR       = 24'h00201a;
    localparam logic [23:0] CFG2_ADDR       = 24'h00201c;
    localparam logic [23:0] START_ADDR      = 24'h002080;
    localparam logic [23:0] ONCHIP_LO_ADDR  = 24'hff2000;
    localparam logic [23:0] ONCHIP_HI_ADDR  = 24'hffffff;

    // ============================================================
    // Reset values and clock multiplier
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [7:0]  CFG_BYTE_RESET = 8'hff;
    localparam logic [2:0]  PLL_MULT       = 3'h4;
    localparam logic [2:0]  PLL_BYPASS     = 3'h1;
    // Pin synchroniser contents under block reset: board reset seen low
    localparam logic [3:0]  PIN_SYNC_RESET = 4'h0;

    // ============================================================
    // Sequencer states, Gray along hold, sync, sequence, run
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_SYNC = 3'b001,
        ST_SEQ  = 3'b011,
        ST_RUN  = 3'b010,
        ST_PROG = 3'b110
    } boot_state_type;

    typedef struct packed {
        logic       reset_b;
        logic       external_access_select;
        logic       prog_level;
        logic       clock_multiplier_select;
    } pin_in_type;

    typedef struct packed {
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
    } chip_config_bytes_type;

endpackage

// [logic/reset_boot_sequencer.sv]
// Reset qualification, clock output resync and post-reset boot sequence
module reset_boot_sequencer
    import reset_boot_pkg::*;
// What this block does
// - Reset low 16 state times resets chip
// - Release resynchronizes clock output before sequence
// - Start-up sequence lasts exactly 10 state times
// - Sequence clears processor status word
// - Load config bytes 2018, 201A, optional 201C
// - Sequence ends with jump to 2080
// - Latch external access select during reset
// - Select high routes upper range on-chip
// - Select low routes upper range off-chip
// - Programming level at reset enters programming mode
// - Multiplier select low bypasses PLL
// - Multiplier select high multiplies by four
// - Clock output 50 percent duty after resync
#(
    parameter int unsigned ADDR_W = 24
) (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_b_i,
    // Board pins and straps, asynchronous
    input  wire pin_in_type            pins_i,
    // Enable for the third config byte, sampled at its read step
    input  wire logic                  byte2_enable_i,
    // Boot fetch port
    output logic                       cfg_rd_o,
    output logic [ADDR_W-1:0]          cfg_addr_o,
    input  wire logic [7:0]            cfg_data_i,
    // Core controls
    output logic                       chip_reset_o,
    output logic                       clock_output_pin_o,
    output logic [15:0]                processor_status_word_o,
    output chip_config_bytes_type      chip_config_bytes_o,
    output logic [ADDR_W-1:0]          start_pc_o,
    output logic                       start_pulse_o,
    output logic                       fetch_enable_o,
    output logic                       prog_mode_o,
    // Memory routing
    input  wire logic [ADDR_W-1:0]     access_addr_i,
    output logic                       route_onchip_o,
    output logic                       route_offchip_o,
    // Clock generator strap outputs
    output logic                       pll_enable_o,
    output logic [2:0]                 pll_mult_o
);

    // ============================================================
    // Functions
    function automatic logic in_upper_range(input logic [ADDR_W-1:0] a);
        in_upper_range = (a >= ONCHIP_LO_ADDR[ADDR_W-1:0]) &&
                         (a <= ONCHIP_HI_ADDR[ADDR_W-1:0]);
    endfunction

    // ============================================================
    // Pin synchronisers
    pin_in_type pin_meta_reg;
    pin_in_type pin_meta_next;
    pin_in_type pin_sync_reg;
    pin_in_type pin_sync_next;

    always_comb begin
        pin_meta_next = pins_i;
        pin_sync_next = pin_meta_reg;
    end

    always_ff @(posedge sys_clk_i) begin
        // Seen as reset low until real levels arrive, so no strap is latched from a guess
        if (!rst_b_i) begin
            pin_meta_reg <= PIN_SYNC_RESET;
            pin_sync_reg <= PIN_SYNC_RESET;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
        end
    end

    // ============================================================
    // Reset pulse qualification
    logic [LOW_CNT_W-1:0] low_cnt_reg;
    logic [LOW_CNT_W-1:0] low_cnt_next;
    logic                 qualified;

    always_comb begin
        low_cnt_next = low_cnt_reg;
        if (pin_sync_reg.reset_b) begin
            low_cnt_next = '0;
        end else if (low_cnt_reg < LOW_CNT_W'(RESET_MIN_STATES)) begin
            low_cnt_next = low_cnt_reg + LOW_CNT_W'(1);
        end
    end

    // Shorter lows are treated as glitches and ignored
    assign qualified = (low_cnt_reg >= LOW_CNT_W'(RESET_MIN_STATES));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            low_cnt_reg <= '0;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    // ============================================================
    // Sequencer state
    boot_state_type       state_reg;
    boot_state_type       state_next;
    logic [SEQ_CNT_W-1:0] seq_cnt_reg;
    logic [SEQ_CNT_W-1:0] seq_cnt_next;
    logic                 ext_latch_reg;
    logic                 ext_latch_next;
    logic                 prog_latch_reg;
    logic                 prog_latch_next;
    logic                 pll_latch_reg;
    logic                 pll_latch_next;

    always_comb begin
        state_next      = state_reg;
        seq_cnt_next    = seq_cnt_reg;
        ext_latch_next  = ext_latch_reg;
        prog_latch_next = prog_latch_reg;
        pll_latch_next  = pll_latch_reg;
        case (state_reg)
            ST_HOLD: begin
                ext_latch_next  = pin_sync_reg.external_access_select;
                prog_latch_next = pin_sync_reg.prog_level;
                pll_latch_next  = pin_sync_reg.clock_multiplier_select;
                if (pin_sync_reg.reset_b) begin
                    state_next = ST_SYNC;
                end
            end
            ST_SYNC: begin
                seq_cnt_next = '0;
                if (prog_latch_reg) begin
                    state_next = ST_PROG;
                end else begin
                    state_next = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (seq_cnt_reg == STEP_JUMP) begin
                    state_next = ST_RUN;
                end else begin
                    seq_cnt_next = seq_cnt_reg + SEQ_CNT_W'(1);
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            ST_PROG: begin
                state_next = ST_PROG;
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
        if (qualified) begin
            state_next   = ST_HOLD;
            seq_cnt_next = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_reg      <= ST_HOLD;
            seq_cnt_reg    <= '0;
            ext_latch_reg  <= 1'b0;
            prog_latch_reg <= 1'b0;
            pll_latch_reg  <= 1'b0;
        end else begin
            state_reg      <= state_next;
            seq_cnt_reg    <= seq_cnt_next;
            ext_latch_reg  <= ext_latch_next;
            prog_latch_reg <= prog_latch_next;
            pll_latch_reg  <= pll_latch_next;
        end
    end

    // ============================================================
    // Boot datapath: status word, config bytes, fetch, jump
    logic                  in_seq;
    logic                  byte2_en_reg;
    logic                  byte2_en_next;
    logic                  cfg_rd_reg;
    logic                  cfg_rd_next;
    logic [ADDR_W-1:0]     cfg_addr_reg;
    logic [ADDR_W-1:0]     cfg_addr_next;
    logic [15:0]           status_word_reg;
    logic [15:0]           status_word_next;
    chip_config_bytes_type cfg_bytes_reg;
    chip_config_bytes_type cfg_bytes_next;
    logic [ADDR_W-1:0]     pc_reg;
    logic [ADDR_W-1:0]     pc_next;
    logic                  start_reg;
    logic                  start_next;

    assign in_seq = (state_reg == ST_SEQ) && !qualified;

    always_comb begin
        byte2_en_next    = byte2_en_reg;
        cfg_rd_next      = 1'b0;
        cfg_addr_next    = cfg_addr_reg;
        status_word_next = status_word_reg;
        cfg_bytes_next   = cfg_bytes_reg;
        pc_next          = pc_reg;
        start_next       = 1'b0;
        if (in_seq) begin
            case (seq_cnt_reg)
                STEP_CLEAR: begin
                    status_word_next = STATUS_RESET;
                    cfg_rd_next      = 1'b1;
                    cfg_addr_next    = CFG0_ADDR[ADDR_W-1:0];
                end
                STEP_CAP0: begin
                    cfg_bytes_next.byte0 = cfg_data_i;
                    cfg_rd_next          = 1'b1;
                    cfg_addr_next        = CFG1_ADDR[ADDR_W-1:0];
                end
                STEP_CAP1: begin
                    cfg_bytes_next.byte1 = cfg_data_i;
                    byte2_en_next        = byte2_enable_i;
                    cfg_rd_next          = byte2_enable_i;
                    cfg_addr_next        = CFG2_ADDR[ADDR_W-1:0];
                end
                STEP_CAP2: begin
                    if (byte2_en_reg) begin
                        cfg_bytes_next.byte2 = cfg_data_i;
                    end
                end
                STEP_JUMP: begin
                    pc_next    = START_ADDR[ADDR_W-1:0];
                    start_next = 1'b1;
                end
                default: begin
                    cfg_rd_next = 1'b0;
                end
            endcase
        end
        // Config bytes keep reset value until reloaded
        if (qualified) begin
            cfg_bytes_next = {3{CFG_BYTE_RESET}};
            byte2_en_next  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            byte2_en_reg    <= 1'b0;
            cfg_rd_reg      <= 1'b0;
            cfg_addr_reg    <= '0;
            status_word_reg <= STATUS_RESET;
            cfg_bytes_reg   <= {3{CFG_BYTE_RESET}};
            pc_reg          <= '0;
            start_reg       <= 1'b0;
        end else begin
            byte2_en_reg    <= byte2_en_next;
            cfg_rd_reg      <= cfg_rd_next;
            cfg_addr_reg    <= cfg_addr_next;
            status_word_reg <= status_word_next;
            cfg_bytes_reg   <= cfg_bytes_next;
            pc_reg       <= pc_next;
            start_reg    <= start_next;
        end
    end

    // ============================================================
    // Clock output, phase forced low until resync completes
    logic clk_out_reg;
    logic clk_out_next;

    // Toggle every state time, even duty
    always_comb begin
        clk_out_next = ~clk_out_reg;
        // Held in phase reset through release
        if (state_reg == ST_HOLD || state_reg == ST_SYNC || qualified) begin
            clk_out_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= clk_out_next;
        end
    end

    // ============================================================
    // Outputs
    // Whole chip held while in reset
    assign chip_reset_o            = (state_reg == ST_HOLD);
    assign clock_output_pin_o      = clk_out_reg;
    assign processor_status_word_o = status_word_reg;
    assign chip_config_bytes_o     = cfg_bytes_reg;
    assign cfg_rd_o                = cfg_rd_reg;
    assign cfg_addr_o              = cfg_addr_reg;
    assign start_pc_o              = pc_reg;
    assign start_pulse_o           = start_reg;
    assign fetch_enable_o          = (state_reg == ST_RUN);
    assign prog_mode_o             = (state_reg == ST_PROG);

    assign route_onchip_o  = fetch_enable_o && ext_latch_reg &&
                             in_upper_range(access_addr_i);
    assign route_offchip_o = fetch_enable_o && !route_onchip_o;

    // Strap latched at reset so a stray toggle cannot glitch the PLL
    // Low bypasses the PLL
    // High selects the times four PLL
    assign pll_enable_o = pll_latch_reg;
    assign pll_mult_o   = pll_latch_reg ? PLL_MULT : PLL_BYPASS;

endmodule

// [dv/board_model.sv]
// Board reset source, static straps and config byte memory
module board_model
    import reset_boot_pkg::*;
(
    // Clock
    input  wire logic        sys_clk_i,
    // Config fetch port
    input  wire logic        cfg_rd_i,
    input  wire logic [23:0] cfg_addr_i,
    output logic [7:0]       cfg_data_o,
    // Board pins
    output pin_in_type       pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Memory and pins
    initial begin
        cfg_data_o = 8'h3c;
        pins_o = 4'h8;
    end

    // Byte valid one cycle only; flips otherwise so stale data never matches
    always @(posedge sys_clk_i) begin
        if (cfg_rd_i) begin
            cfg_data_o <= cfg_addr_i[7:0] ^ 8'ha5;
        end else begin
            cfg_data_o <= ~cfg_data_o;
        end
    end

    // low n cycles, straps only move under reset
    task automatic pulse_reset(input int n, input logic ext, input logic pr, input logic pl);
        @(posedge sys_clk_i);
        pins_o <= {1'b0, ext, pr, pl};
        repeat (n) @(posedge sys_clk_i);
        pins_o.reset_b <= 1'b1;
    endtask
endmodule

// [dv/reset_boot_sequencer_monitor.sv]
// Port checker for the reset and boot sequencer
module reset_boot_sequencer_monitor
    import reset_boot_pkg::*;
#(
    parameter int unsigned ADDR_W = 24
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_b_i,
    input wire pin_in_type        pins_i,
    input wire logic              cfg_rd_o,
    input wire logic [ADDR_W-1:0] cfg_addr_o,
    input wire logic              chip_reset_o,
    input wire logic              clock_output_pin_o,
    input wire logic [15:0]       processor_status_word_o,
    input wire logic [ADDR_W-1:0] start_pc_o,
    input wire logic              start_pulse_o,
    input wire logic              fetch_enable_o,
    input wire logic              prog_mode_o,
    input wire logic [ADDR_W-1:0] access_addr_i,
    input wire logic              route_onchip_o,
    input wire logic              route_offchip_o,
    input wire logic              pll_enable_o,
    input wire logic [2:0]        pll_mult_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ============================================================
    // Raw board low run length, sync delay allowed for
    logic [4:0] low_cnt_reg;
    logic [4:0] low_cnt_next;
    always_comb begin
        low_cnt_next = 5'h00;
        if (!pins_i.reset_b && low_cnt_reg != 5'h1f) begin
            low_cnt_next = low_cnt_reg + 5'h01;
        end else if (!pins_i.reset_b) begin
            low_cnt_next = low_cnt_reg;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        low_cnt_reg <= rst_b_i ? low_cnt_next : 5'h00;
    end

    sequence boot_go;
        $fell(chip_reset_o) ##1 !prog_mode_o;
    endsequence
    sequence boot_reads;
        cfg_rd_o && cfg_addr_o == CFG0_ADDR ##2 cfg_rd_o && cfg_addr_o == CFG1_ADDR;
    endsequence
    sequence boot_wait;
        !fetch_enable_o [*8] ##1 !fetch_enable_o [*2] ##1 fetch_enable_o;
    endsequence

    boot_len_a: assert property (disable iff (!rst_b_i || chip_reset_o)
        boot_go |-> boot_wait ##0 start_pulse_o && start_pc_o == START_ADDR)
        else $error("boot length or jump wrong");
    cfg_order_a: assert property (disable iff (!rst_b_i || chip_reset_o)
        boot_go |-> ##1 boot_reads) else $error("config reads out of order");
    psw_clear_a: assert property ($rose(fetch_enable_o) |->
        processor_status_word_o == STATUS_RESET) else $error("status word not clear");
    start_once_a: assert property (start_pulse_o |-> $rose(fetch_enable_o))
        else $error("jump pulse outside start");
    fetch_held_a: assert property (chip_reset_o || prog_mode_o |->
        !fetch_enable_o && !cfg_rd_o) else $error("fetch during reset");
    reset_qual_a: assert property (low_cnt_reg == 5'h16 |-> chip_reset_o)
        else $error("long low not taken");
    short_skip_a: assert property (fetch_enable_o && low_cnt_reg < 5'h0c |=>
        fetch_enable_o) else $error("short low taken");
    clk_hold_a: assert property (chip_reset_o |-> !clock_output_pin_o)
        else $error("clock out runs in reset");
    clk_duty_a: assert property (fetch_enable_o ##1 fetch_enable_o |->
        clock_output_pin_o != $past(clock_output_pin_o)) else $error("clock out stuck");
    route_sel_a: assert property (route_onchip_o |->
        fetch_enable_o && !route_offchip_o && access_addr_i >= ONCHIP_LO_ADDR)
        else $error("route wrong");
    pll_mult_a: assert property (pll_mult_o == (pll_enable_o ? PLL_MULT : PLL_BYPASS))
        else $error("multiplier wrong");
    strap_frozen_a: assert property (!chip_reset_o ##1 !chip_reset_o |->
        $stable(pll_enable_o)) else $error("strap moved");
endmodule

bind reset_boot_sequencer reset_boot_sequencer_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// [dv/reset_boot_sequencer_tb.sv]
// Self-checking bench for the reset and boot sequencer
module reset_boot_sequencer_tb
    import reset_boot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic byte2_enable_i = 1'b0;
    logic [23:0] access_addr_i = 24'h000000;
    pin_in_type pins;
    logic [7:0] cfg_data;
    logic cfg_rd_o, chip_reset_o, clock_output_pin_o, start_pulse_o;
    logic fetch_enable_o, prog_mode_o, route_onchip_o, route_offchip_o, pll_enable_o;
    logic [23:0] cfg_addr_o, start_pc_o;
    logic [15:0] processor_status_word_o;
    chip_config_bytes_type chip_config_bytes_o;
    logic [2:0] pll_mult_o;
    int err_total = 0;
    int samples_checked = 0;
    int rd_seen = 0;
    int cycle_count = 0;

    reset_boot_sequencer u_reset_boot_sequencer (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .pins_i(pins), .byte2_enable_i(byte2_enable_i), .cfg_rd_o(cfg_rd_o),
        .cfg_addr_o(cfg_addr_o), .cfg_data_i(cfg_data), .chip_reset_o(chip_reset_o),
        .clock_output_pin_o(clock_output_pin_o), .processor_status_word_o(processor_status_word_o),
        .chip_config_bytes_o(chip_config_bytes_o), .start_pc_o(start_pc_o),
        .start_pulse_o(start_pulse_o), .fetch_enable_o(fetch_enable_o), .prog_mode_o(prog_mode_o),
        .access_addr_i(access_addr_i), .route_onchip_o(route_onchip_o),
        .route_offchip_o(route_offchip_o), .pll_enable_o(pll_enable_o), .pll_mult_o(pll_mult_o));
    board_model u_board_model (.sys_clk_i(sys_clk_i), .cfg_rd_i(cfg_rd_o),
        .cfg_addr_i(cfg_addr_o), .cfg_data_o(cfg_data), .pins_o(pins));

    // ============================================================
    // Clock, read counter, hang guard
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (cfg_rd_o === 1'b1) rd_seen++;
        cycle_count++;
        if (cycle_count == 2000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic wait_run(input logic ext, input logic pl, input logic en2);
        int n;
        logic [23:0] a [4];
        a = '{24'hff2000, 24'hffffff, 24'hff1fff, 24'h002080};
        n = 0;
        while (fetch_enable_o !== 1'b1 && n < 40) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check(start_pulse_o, 1'b1);
        check(start_pc_o, 24'h002080);
        check(processor_status_word_o, 24'h000000);
        check(chip_config_bytes_o, {en2 ? 8'h1c ^ 8'ha5 : 8'hff, 8'hbf, 8'hbd});
        check(24'(rd_seen), en2 ? 24'd3 : 24'd2);
        check(prog_mode_o, 1'b0);
        check(pll_enable_o, pl);
        check(pll_mult_o, pl ? 24'h4 : 24'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            access_addr_i <= a[i];
            #1;
            check(route_onchip_o, ext && a[i] >= 24'hff2000);
            check(route_offchip_o, !(ext && a[i] >= 24'hff2000));
        end
    endtask

    task automatic boot(input logic ext, input logic pl, input logic en2);
        @(posedge sys_clk_i);
        byte2_enable_i <= en2;
        rd_seen = 0;
        u_board_model.pulse_reset(24, ext, 1'b0, pl);
        #1;
        check(chip_reset_o, 1'b1);
        check(fetch_enable_o, 1'b0);
        check(chip_config_bytes_o, 24'hffffff);
        wait_run(ext, pl, en2);
    endtask

    task automatic short_pulse();
        u_board_model.pulse_reset(10, 1'b1, 1'b0, 1'b1);
        repeat (4) @(posedge sys_clk_i);
        #1;
        check(fetch_enable_o, 1'b1);
        check(chip_reset_o, 1'b0);
    endtask

    task automatic prog_entry();
        rd_seen = 0;
        u_board_model.pulse_reset(24, 1'b1, 1'b1, 1'b0);
        repeat (20) @(posedge sys_clk_i);
        #1;
        check(prog_mode_o, 1'b1);
        check(fetch_enable_o, 1'b0);
        check(24'(rd_seen), 24'd0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        wait_run(1'b0, 1'b0, 1'b0);
        boot(1'b1, 1'b1, 1'b1);
        short_pulse();
        boot(1'b0, 1'b0, 1'b1);
        boot(1'b1, 1'b0, 1'b0);
        prog_entry();
        boot(1'b0, 1'b1, 1'b1);
        end_of_test();
    end
endmodule
